// >>> design/fes_pkg.sv
// Constants and types for the flash erase-select, fail-address and user test block
package fes_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] ADDR_LMS = 8'h00;
    localparam logic [7:0] ADDR_ADR = 8'h04;
    localparam logic [7:0] ADDR_UT0 = 8'h08;
    localparam logic [7:0] ADDR_UT1 = 8'h0C;
    localparam logic [7:0] ADDR_UT2 = 8'h10;
    localparam logic [7:0] ADDR_MISR0 = 8'h14;
    localparam logic [7:0] ADDR_MISR4 = 8'h24;
    localparam logic [7:0] ADDR_STAT = 8'h28;
    // Erase block select layout
    localparam int LMS_LOW_LSB = 0;
    localparam int LMS_LOW_W = 6;
    localparam int LMS_MID_LSB = 16;
    localparam int LMS_MID_W = 2;
    localparam logic [7:0] SECTOR_PRESENT = 8'hFF;
    localparam logic [7:0] LMS_RESET = 8'h00;
    // User test 0 layout
    localparam int UT0_UNLOCK = 31;
    localparam int UT0_DSI_LSB = 16;
    localparam int UT0_X = 7;
    localparam int UT0_MARGIN_EN = 5;
    localparam int UT0_MARGIN_LVL = 4;
    localparam int UT0_ECC_EN = 3;
    localparam int UT0_SEQ_SEL = 2;
    localparam int UT0_START = 1;
    localparam int UT0_AID = 0;
    localparam logic [31:0] UNLOCK_PASSWORD = 32'hF9F99999;
    // Capture event order, highest priority first; also status bit positions
    localparam int EV_DBL = 0;
    localparam int EV_RWW = 1;
    localparam int EV_PE = 2;
    localparam int EV_SGL = 3;
    localparam int ADR_LSB = 3;
    localparam int ADR_MSB = 22;
    // Integrity check walks page 0 up to this page
    localparam logic [18:0] AI_LAST_PAGE = 19'h0000F;
    localparam logic [159:0] MISR_RESET = 160'h0;

    typedef enum logic [1:0] {
        FES_AI_IDLE = 2'b00,
        FES_AI_REQ = 2'b01,
        FES_AI_WAIT = 2'b10
    } fes_ai_state_t;

    typedef struct packed {
        logic [7:0] sel;
        logic unlocked;
        logic [7:0] dsi;
        logic x;
        logic margin_en;
        logic margin_lvl;
        logic ecc_en;
        logic seq_sel;
        logic start;
        logic integrity_done_flag;
        logic [63:0] force_word;
        logic [159:0] misr;
        logic [3:0] flag;
        logic [3:0][19:0] cap;
        fes_ai_state_t ai_st;
        logic [18:0] ai_cnt;
        logic [31:0] prdata;
        logic pslverr;
    } fes_state_t;
endpackage : fes_pkg

// >>> design/fes_top.sv
// Erase block select, failing address capture and user test logic with APB slave
//
// Operation
// - Select bit one includes sector; reset cleared
// - Mid bits sectors 7-6, low 5-0
// - Ignore select writes after interlock or suspend
// - Absent sectors read unselected, writes ignored
// - Capture first address of four events
// - Show highest-priority pending event address
// - Double-word address; both words clear bit3
// - Guarded test fields locked unless done flags
// - Password sets unlock; writing bit 31 zero clears it
// - Syndrome force bits drive ECC check
// - Reserved test bit stores and reads back
// - Margin reads only inside integrity checks
// - Margin level: one erased, zero programmed
// - ECC input enable turns logic check on while unlocked
// - Sequence select: vendor or sequential order
// - Start bit begins integrity check sweep
// - Start accepted only without erase/program/HV
// - Done flag clears at start, sets end
// - Low force word drives even ECC word
// - Signatures accumulate pages, writable seed
// - High force word drives odd ECC word
`timescale 1ns/1ps
module fes_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ctl_done,
    input wire logic ctl_erase_operation,
    input wire logic ctl_program_operation,
    input wire logic ctl_high_voltage_enable,
    input wire logic ctl_interlock_written,
    input wire logic ctl_hv_suspended,
    input wire logic [7:0] block_locked,
    input wire logic [1:0] ev_double_error,
    input wire logic ev_read_while_write_fault,
    input wire logic ev_program_erase_fail,
    input wire logic [1:0] ev_single_error_corrected,
    input wire logic [22:3] ev_addr,
    output logic [7:0] erase_select,
    output logic [7:0] ai_block_mask,
    output logic ai_read_req,
    output logic [18:0] ai_page,
    output logic ai_margin_read,
    output logic ai_margin_level,
    output logic ai_sequential,
    input wire logic ai_rvalid,
    input wire logic [159:0] ai_rdata,
    output logic ecc_check_enable,
    output logic [7:0] ecc_syndrome_force,
    output logic [63:0] ecc_data_force
);
    fes_pkg::fes_state_t s_q;
    fes_pkg::fes_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Signature step: rotate, tap, fold in the page
    function automatic logic [159:0] misr_step(input logic [159:0] old, input logic [159:0] din);
        logic fb;
        fb = old[159] ^ old[154] ^ old[137] ^ old[0];
        misr_step = {old[158:0], fb} ^ din;
    endfunction : misr_step

    // Both words of a page hit: bit 3 reads zero
    function automatic logic [19:0] dword_addr(input logic [22:3] a, input logic [1:0] hit);
        dword_addr = {a[22:4], (hit == 2'b01) ? 1'b0 : ((hit == 2'b10) ? 1'b1 : 1'b0)};
    endfunction : dword_addr

    ////////////////////////////////////////////////////////////////////////
    // Decode and controller status

    logic setup;
    logic access;
    logic wr;
    logic guard;
    logic misr_hit;
    logic [2:0] misr_idx;
    logic mapped;
    logic [31:0] ut0_rd;
    logic [31:0] stat_rd;
    logic [19:0] adr_sel;
    logic ai_busy;
    logic [3:0] ev_any;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite && !s_q.pslverr;
    assign guard = ctl_done && s_q.integrity_done_flag;
    assign misr_hit = (paddr >= fes_pkg::ADDR_MISR0) && (paddr <= fes_pkg::ADDR_MISR4) && (paddr[1:0] == 2'b00);
    assign misr_idx = 3'((paddr - fes_pkg::ADDR_MISR0) >> 2);
    assign mapped = misr_hit || (paddr == fes_pkg::ADDR_LMS) || (paddr == fes_pkg::ADDR_ADR)
        || (paddr == fes_pkg::ADDR_UT0) || (paddr == fes_pkg::ADDR_UT1) || (paddr == fes_pkg::ADDR_UT2)
        || (paddr == fes_pkg::ADDR_STAT);
    assign ai_busy = s_q.ai_st != fes_pkg::FES_AI_IDLE;
    assign ev_any = {|ev_single_error_corrected, ev_program_erase_fail, ev_read_while_write_fault,
        |ev_double_error};

    // Guarded fields read as zero while locked out
    always_comb begin
        ut0_rd = 32'h00000000;
        ut0_rd[fes_pkg::UT0_UNLOCK] = s_q.unlocked;
        ut0_rd[fes_pkg::UT0_START] = s_q.start;
        ut0_rd[fes_pkg::UT0_AID] = s_q.integrity_done_flag;
        if (guard) begin
            ut0_rd[fes_pkg::UT0_DSI_LSB +: 8] = s_q.dsi;
            ut0_rd[fes_pkg::UT0_X] = s_q.x;
            ut0_rd[fes_pkg::UT0_MARGIN_EN] = s_q.margin_en;
            ut0_rd[fes_pkg::UT0_MARGIN_LVL] = s_q.margin_lvl;
            ut0_rd[fes_pkg::UT0_ECC_EN] = s_q.ecc_en;
            ut0_rd[fes_pkg::UT0_SEQ_SEL] = s_q.seq_sel;
        end
        stat_rd = {28'h0000000, s_q.flag};
    end

    // Pending flag of highest priority owns the address
    always_comb begin
        adr_sel = 20'h00000;
        if (s_q.flag[fes_pkg::EV_DBL]) begin
            adr_sel = s_q.cap[fes_pkg::EV_DBL];
        end else if (s_q.flag[fes_pkg::EV_RWW]) begin
            adr_sel = s_q.cap[fes_pkg::EV_RWW];
        end else if (s_q.flag[fes_pkg::EV_PE]) begin
            adr_sel = s_q.cap[fes_pkg::EV_PE];
        end else if (s_q.flag[fes_pkg::EV_SGL]) begin
            adr_sel = s_q.cap[fes_pkg::EV_SGL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        // Read data and error latched in setup, so the access phase needs no wait
        if (setup) begin
            s_d.pslverr = !mapped;
            s_d.prdata = 32'h00000000;
            if (!pwrite) begin
                unique case (1'b1)
                    paddr == fes_pkg::ADDR_LMS: begin
                        s_d.prdata[fes_pkg::LMS_LOW_LSB +: fes_pkg::LMS_LOW_W] = s_q.sel[5:0];
                        s_d.prdata[fes_pkg::LMS_MID_LSB +: fes_pkg::LMS_MID_W] = s_q.sel[7:6];
                    end
                    paddr == fes_pkg::ADDR_ADR: s_d.prdata[fes_pkg::ADR_MSB:fes_pkg::ADR_LSB] = adr_sel;
                    paddr == fes_pkg::ADDR_UT0: s_d.prdata = ut0_rd;
                    paddr == fes_pkg::ADDR_UT1: s_d.prdata = guard ? s_q.force_word[31:0] : 32'h00000000;
                    paddr == fes_pkg::ADDR_UT2: s_d.prdata = guard ? s_q.force_word[63:32] : 32'h00000000;
                    paddr == fes_pkg::ADDR_STAT: s_d.prdata = stat_rd;
                    misr_hit: s_d.prdata = guard ? s_q.misr[32 * misr_idx +: 32] : 32'h00000000;
                    default: s_d.prdata = 32'h00000000;
                endcase
            end
        end

        // Erase block select
        if (wr && paddr == fes_pkg::ADDR_LMS && !ctl_interlock_written && !ctl_hv_suspended) begin
            if (pstrb[0]) begin
                s_d.sel[5:0] = pwdata[fes_pkg::LMS_LOW_LSB +: fes_pkg::LMS_LOW_W];
            end
            if (pstrb[2]) begin
                s_d.sel[7:6] = pwdata[fes_pkg::LMS_MID_LSB +: fes_pkg::LMS_MID_W];
            end
        end
        s_d.sel = s_d.sel & fes_pkg::SECTOR_PRESENT;

        // User test 0: password, unlock clear, fields, start
        if (wr && paddr == fes_pkg::ADDR_UT0) begin
            if (pwdata == fes_pkg::UNLOCK_PASSWORD && pstrb == 4'hF) begin
                s_d.unlocked = 1'b1;
            end else if (s_q.unlocked) begin
                if (pstrb[3] && !pwdata[fes_pkg::UT0_UNLOCK]) begin
                    s_d.unlocked = 1'b0;
                end
                if (guard && pstrb[2]) begin
                    s_d.dsi = pwdata[fes_pkg::UT0_DSI_LSB +: 8];
                end
                if (guard && pstrb[0]) begin
                    s_d.x = pwdata[fes_pkg::UT0_X];
                    s_d.margin_en = pwdata[fes_pkg::UT0_MARGIN_EN];
                    s_d.margin_lvl = pwdata[fes_pkg::UT0_MARGIN_LVL];
                    s_d.ecc_en = pwdata[fes_pkg::UT0_ECC_EN];
                    s_d.seq_sel = pwdata[fes_pkg::UT0_SEQ_SEL];
                end
                if (pstrb[0]) begin
                    if (!pwdata[fes_pkg::UT0_START]) begin
                        s_d.start = 1'b0;
                    end else if (!s_q.start && !ai_busy && !ctl_erase_operation && !ctl_program_operation
                        && !ctl_high_voltage_enable) begin
                        s_d.start = 1'b1;
                        s_d.integrity_done_flag = 1'b0;
                        s_d.ai_cnt = 19'h00000;
                        s_d.ai_st = fes_pkg::FES_AI_REQ;
                    end
                end
            end
        end

        // Forced data words and signature seeds
        if (wr && s_q.unlocked && guard && pstrb == 4'hF) begin
            if (paddr == fes_pkg::ADDR_UT1) begin
                s_d.force_word[31:0] = pwdata;
            end
            if (paddr == fes_pkg::ADDR_UT2) begin
                s_d.force_word[63:32] = pwdata;
            end
            if (misr_hit) begin
                s_d.misr[32 * misr_idx +: 32] = pwdata;
            end
        end

        // Integrity check sweep
        unique case (s_q.ai_st)
            fes_pkg::FES_AI_IDLE: begin
            end
            fes_pkg::FES_AI_REQ: s_d.ai_st = fes_pkg::FES_AI_WAIT;
            fes_pkg::FES_AI_WAIT: begin
                if (ai_rvalid) begin
                    s_d.misr = misr_step(s_q.misr, ai_rdata);
                    if (s_q.ai_cnt == fes_pkg::AI_LAST_PAGE) begin
                        s_d.integrity_done_flag = 1'b1;
                        s_d.ai_st = fes_pkg::FES_AI_IDLE;
                    end else begin
                        s_d.ai_cnt = 19'(s_q.ai_cnt + 19'h00001);
                        s_d.ai_st = fes_pkg::FES_AI_REQ;
                    end
                end
            end
            default: s_d.ai_st = fes_pkg::FES_AI_IDLE;
        endcase

        // Failing address capture; clear by writing one, a new event wins
        if (wr && paddr == fes_pkg::ADDR_STAT && pstrb[0]) begin
            s_d.flag = s_q.flag & ~pwdata[3:0];
        end
        for (int i = 0; i < 4; i++) begin
            if (ev_any[i]) begin
                s_d.flag[i] = 1'b1;
                if (!s_q.flag[i]) begin
                    s_d.cap[i] = ev_addr;
                end
            end
        end
        if (!s_q.flag[fes_pkg::EV_DBL] && |ev_double_error) begin
            s_d.cap[fes_pkg::EV_DBL] = dword_addr(ev_addr, ev_double_error);
        end
        if (!s_q.flag[fes_pkg::EV_SGL] && |ev_single_error_corrected) begin
            s_d.cap[fes_pkg::EV_SGL] = dword_addr(ev_addr, ev_single_error_corrected);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{sel: fes_pkg::LMS_RESET, unlocked: 1'b0, dsi: 8'h00, x: 1'b0, margin_en: 1'b0,
                margin_lvl: 1'b0, ecc_en: 1'b0, seq_sel: 1'b0, start: 1'b0, integrity_done_flag: 1'b1, force_word: 64'h0,
                misr: fes_pkg::MISR_RESET,
                flag: 4'h0, cap: '0, ai_st: fes_pkg::FES_AI_IDLE, ai_cnt: 19'h00000,
                prdata: 32'h00000000, pslverr: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = access && s_q.pslverr;
    assign erase_select = s_q.sel;
    assign ai_block_mask = s_q.sel & ~block_locked;
    assign ai_read_req = s_q.ai_st == fes_pkg::FES_AI_REQ;
    // Vendor order is the gray-coded walk; sequential is plain count
    assign ai_page = s_q.seq_sel ? s_q.ai_cnt : (s_q.ai_cnt ^ (s_q.ai_cnt >> 1));
    assign ai_margin_read = s_q.margin_en && ai_busy;
    assign ai_margin_level = s_q.margin_lvl;
    assign ai_sequential = s_q.seq_sel;
    assign ecc_check_enable = s_q.ecc_en && s_q.unlocked;
    assign ecc_syndrome_force = s_q.dsi;
    assign ecc_data_force = s_q.force_word;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_lms_locked;
        wr && paddr == fes_pkg::ADDR_LMS && (ctl_interlock_written || ctl_hv_suspended) |=> $stable(s_q.sel);
    endproperty
    a_lms_locked: assert property (p_lms_locked) else $error("select changed while locked");

    property p_absent;
        (erase_select & ~fes_pkg::SECTOR_PRESENT) == 8'h00;
    endproperty
    a_absent: assert property (p_absent) else $error("absent sector selected");

    property p_unlock;
        $rose(s_q.unlocked) |-> $past(wr && paddr == fes_pkg::ADDR_UT0 && pwdata == fes_pkg::UNLOCK_PASSWORD);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock without password");

    property p_guard;
        !$past(guard) && $past(wr) |-> $stable(s_q.dsi) && $stable(s_q.margin_en) && $stable(s_q.force_word);
    endproperty
    a_guard: assert property (p_guard) else $error("guarded field written");

    property p_start_gate;
        $rose(s_q.start) |-> $past(!ctl_erase_operation && !ctl_program_operation && !ctl_high_voltage_enable);
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("start accepted during operation");

    property p_done_clear;
        $rose(s_q.start) |-> !s_q.integrity_done_flag && ai_read_req;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done not cleared on start");

    property p_req_pulse;
        ai_read_req |=> !ai_read_req;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("page request longer than one cycle");

    property p_lock_force;
        !s_q.unlocked && wr && (paddr == fes_pkg::ADDR_UT1 || paddr == fes_pkg::ADDR_UT2) |=> $stable(s_q.force_word);
    endproperty
    a_lock_force: assert property (p_lock_force) else $error("forced word written while locked");

    property p_ecc_lock;
        !s_q.unlocked |-> !ecc_check_enable;
    endproperty
    a_ecc_lock: assert property (p_ecc_lock) else $error("logic check enabled while locked");

    property p_flag_set;
        ev_double_error != 2'b00 |=> s_q.flag[fes_pkg::EV_DBL];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("double error not flagged");

    property p_margin;
        ai_margin_read |-> ai_busy;
    endproperty
    a_margin: assert property (p_margin) else $error("margin read outside check");

    property p_capture_hold;
        s_q.flag[fes_pkg::EV_DBL] && $past(s_q.flag[fes_pkg::EV_DBL]) |-> $stable(s_q.cap[fes_pkg::EV_DBL]);
    endproperty
    a_capture_hold: assert property (p_capture_hold) else $error("capture overwritten");

    property p_priority;
        s_q.flag[fes_pkg::EV_DBL] |-> adr_sel == s_q.cap[fes_pkg::EV_DBL];
    endproperty
    a_priority: assert property (p_priority) else $error("wrong address priority");

    property p_both_bit3;
        !s_q.flag[fes_pkg::EV_DBL] && ev_double_error == 2'b11 |=> s_q.cap[fes_pkg::EV_DBL][0] == 1'b0;
    endproperty
    a_both_bit3: assert property (p_both_bit3) else $error("bit 3 set for both words");

    c_check_done: cover property ($rose(s_q.integrity_done_flag));
    c_unlock: cover property ($rose(s_q.unlocked));
    c_double_capture: cover property ($rose(s_q.flag[fes_pkg::EV_DBL]));
    c_select_write: cover property (wr && paddr == fes_pkg::ADDR_LMS ##1 erase_select != 8'h00);
endmodule : fes_top

// >>> testbench/fes_flash_model.sv
// Flash array model answering integrity check page reads
`timescale 1ns/1ps
module fes_flash_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ai_read_req,
    input wire logic [18:0] ai_page,
    output logic ai_rvalid,
    output logic [159:0] ai_rdata
);
    logic busy_q;
    logic [2:0] wait_q;
    logic [18:0] page_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Odd pages answer slowly, even pages at once; data churns while not valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            wait_q <= 3'h0;
            page_q <= '0;
            ai_rvalid <= 1'b0;
            ai_rdata <= '0;
        end else begin
            ai_rvalid <= 1'b0;
            ai_rdata <= ~ai_rdata;
            if (ai_read_req && !busy_q) begin
                busy_q <= 1'b1;
                page_q <= ai_page;
                wait_q <= ai_page[0] ? 3'h4 : 3'h0;
            end else if (busy_q && wait_q == 3'h0) begin
                busy_q <= 1'b0;
                ai_rvalid <= 1'b1;
                ai_rdata <= {20{page_q[7:0] ^ 8'h5A}};
            end else if (busy_q) begin
                wait_q <= wait_q - 3'h1;
            end
        end
    end
endmodule : fes_flash_model

// >>> testbench/test_fes_top.sv
// Self-checking testbench for the erase select, fail address and user test block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_fes_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, erase_select, ai_block_mask, ecc_syndrome_force;
    logic [31:0] pwdata, prdata, rd;
    logic ctl_done, ctl_erase_operation, ctl_interlock_written, ctl_hv_suspended;
    logic ctl_program_operation, ctl_high_voltage_enable;
    logic [7:0] block_locked;
    logic [5:0] evs;
    logic [22:3] ev_addr;
    logic ai_read_req, ai_margin_read, ai_margin_level, ai_sequential, ai_rvalid, ecc_check_enable;
    logic [18:0] ai_page;
    logic [159:0] ai_rdata, m;
    logic [63:0] ecc_data_force;
    int fails, total_checks;
    logic [18:0] pq[$];
    logic [1:0] mq[$];

    fes_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
        .pslverr, .ctl_done, .ctl_erase_operation, .ctl_program_operation, .ctl_high_voltage_enable,
        .ctl_interlock_written, .ctl_hv_suspended, .block_locked, .ev_double_error(evs[1:0]),
        .ev_read_while_write_fault(evs[2]), .ev_program_erase_fail(evs[3]), .ev_single_error_corrected(evs[5:4]),
        .ev_addr, .erase_select, .ai_block_mask, .ai_read_req, .ai_page, .ai_margin_read, .ai_margin_level,
        .ai_sequential, .ai_rvalid, .ai_rdata, .ecc_check_enable, .ecc_syndrome_force, .ecc_data_force);
    fes_flash_model FLASH (.pclk, .presetn, .ai_read_req, .ai_page, .ai_rvalid, .ai_rdata);

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(negedge pclk) begin
        if (ai_read_req === 1'b1) begin
            pq.push_back(ai_page);
            mq.push_back({ai_margin_read, ai_margin_level});
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Answer taken at the rising edge where pready is seen high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK(rd, e)
    endtask : rchk

    task automatic ev(input logic [5:0] e, input logic [22:3] a);
        @(posedge pclk);
        evs <= e;
        ev_addr <= a;
        @(posedge pclk);
        evs <= 6'h00;
        @(negedge pclk);
    endtask : ev

    task automatic run(input logic [31:0] cfg);
        int i;
        logic [18:0] p;
        pq.delete();
        mq.delete();
        m = {32'h55555555, 32'h44444444, 32'h33333333, 32'h22222222, 32'h11111111};
        for (i = 0; i < 5; i++) wr(fes_pkg::ADDR_MISR0 + 8'(4 * i), m[32 * i +: 32]);
        wr(fes_pkg::ADDR_UT0, cfg);
        wr(fes_pkg::ADDR_UT0, cfg | 32'h2);
        xfer(fes_pkg::ADDR_UT0, 1'b0, 32'h0);
        `CHK(rd[0], 1'b0)
        `CHK(rd[23:2], 22'h0)
        i = 0;
        do begin
            xfer(fes_pkg::ADDR_UT0, 1'b0, 32'h0);
            i++;
        end while (rd[0] !== 1'b1 && i < 100);
        `CHK(rd[0], 1'b1)
        `CHK(pq.size(), 16)
        for (i = 0; i < pq.size(); i++) begin
            p = cfg[2] ? 19'(i) : 19'(i ^ (i >> 1));
            `CHK(pq[i], p)
            `CHK(mq[i], cfg[5:4])
            m = {m[158:0], m[159] ^ m[154] ^ m[137] ^ m[0]} ^ {20{p[7:0] ^ 8'h5A}};
        end
        for (i = 0; i < 5; i++) rchk(fes_pkg::ADDR_MISR0 + 8'(4 * i), m[32 * i +: 32]);
        `CHK(ai_margin_read, 1'b0)
    endtask : run

    task automatic test_done();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // Whole sequence needs a few hundred cycles
    initial begin
        #200us;
        fails++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, evs, ev_addr} = '0;
        {ctl_erase_operation, ctl_program_operation, ctl_high_voltage_enable} = 3'b000;
        {ctl_interlock_written, ctl_hv_suspended} = 2'b00;
        ctl_done = 1'b1;
        block_locked = 8'h0F;
        fails = 0;
        total_checks = 0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk(fes_pkg::ADDR_LMS, 32'h0);
        wr(fes_pkg::ADDR_LMS, 32'hFFFF_FFFF);
        rchk(fes_pkg::ADDR_LMS, 32'h0003_003F);
        `CHK(erase_select, 8'hFF)
        `CHK(ai_block_mask, 8'hF0)
        @(posedge pclk) ctl_interlock_written <= 1'b1;
        wr(fes_pkg::ADDR_LMS, 32'h0);
        rchk(fes_pkg::ADDR_LMS, 32'h0003_003F);
        @(posedge pclk) ctl_interlock_written <= 1'b0;
        @(posedge pclk) ctl_hv_suspended <= 1'b1;
        wr(fes_pkg::ADDR_LMS, 32'h0);
        rchk(fes_pkg::ADDR_LMS, 32'h0003_003F);
        @(posedge pclk) ctl_hv_suspended <= 1'b0;
        wr(fes_pkg::ADDR_LMS, 32'h0001_0005);
        rchk(fes_pkg::ADDR_LMS, 32'h0001_0005);
        `CHK(erase_select, 8'h45)
        rchk(fes_pkg::ADDR_UT0, 32'h1);
        wr(fes_pkg::ADDR_UT1, 32'h1234_5678);
        `CHK(ecc_data_force, 64'h0)
        wr(fes_pkg::ADDR_UT0, fes_pkg::UNLOCK_PASSWORD);
        rchk(fes_pkg::ADDR_UT0, 32'h8000_0001);
        wr(fes_pkg::ADDR_UT0, 32'h80A5_00B8);
        rchk(fes_pkg::ADDR_UT0, 32'h80A5_00B9);
        `CHK(ecc_syndrome_force, 8'hA5)
        `CHK(ecc_check_enable, 1'b1)
        `CHK(ai_margin_read, 1'b0)
        wr(fes_pkg::ADDR_UT1, 32'h1234_5678);
        wr(fes_pkg::ADDR_UT2, 32'h9ABC_DEF0);
        `CHK(ecc_data_force, 64'h9ABC_DEF0_1234_5678)
        @(posedge pclk) ctl_done <= 1'b0;
        wr(fes_pkg::ADDR_UT1, 32'h0);
        rchk(fes_pkg::ADDR_UT1, 32'h0);
        @(posedge pclk) ctl_done <= 1'b1;
        rchk(fes_pkg::ADDR_UT1, 32'h1234_5678);
        xfer(8'h2C, 1'b0, 32'h0);
        `CHK(er, 1'b1)
        for (int k = 0; k < 3; k++) begin
            @(posedge pclk) {ctl_erase_operation, ctl_program_operation, ctl_high_voltage_enable} <= 3'(4 >> k);
            wr(fes_pkg::ADDR_UT0, 32'h8000_0036);
            rchk(fes_pkg::ADDR_UT0, 32'h8000_0035);
            `CHK(pq.size(), 0)
        end
        @(posedge pclk) {ctl_erase_operation, ctl_program_operation, ctl_high_voltage_enable} <= 3'b000;
        run(32'h8000_0034);
        `CHK(ecc_check_enable, 1'b0)
        run(32'h8000_0000);
        ev(6'b110000, 20'h00011);
        rchk(fes_pkg::ADDR_ADR, 32'h0000_0080);
        ev(6'b001000, 20'h00100);
        rchk(fes_pkg::ADDR_ADR, 32'h0000_0800);
        ev(6'b000010, 20'h00200);
        rchk(fes_pkg::ADDR_ADR, 32'h0000_1008);
        ev(6'b000001, 20'h00300);
        rchk(fes_pkg::ADDR_ADR, 32'h0000_1008);
        rchk(fes_pkg::ADDR_STAT, 32'h0000_000D);
        wr(fes_pkg::ADDR_STAT, 32'h1);
        rchk(fes_pkg::ADDR_ADR, 32'h0000_0800);
        ev(6'b000100, 20'h00400);
        rchk(fes_pkg::ADDR_ADR, 32'h0000_2000);
        wr(fes_pkg::ADDR_STAT, 32'hF);
        rchk(fes_pkg::ADDR_STAT, 32'h0);
        ev(6'b010000, 20'h00501);
        rchk(fes_pkg::ADDR_ADR, 32'h0000_2800);
        ev(6'b000011, 20'h00601);
        rchk(fes_pkg::ADDR_ADR, 32'h0000_3000);
        wr(fes_pkg::ADDR_UT0, 32'h0);
        wr(fes_pkg::ADDR_UT1, 32'h0);
        `CHK(ecc_data_force[31:0], 32'h1234_5678)
        test_done();
    end
endmodule : test_fes_top
